// ---- rtl/pll_ctl_pkg.sv ----
// Constants, register offsets and field layouts of the loop control block.
// Assumes a single 20 MHz system clock with all link inputs synchronous to it.
package pll_ctl_pkg;

    // Register offsets on the register port
    localparam logic [7:0] CTRL_OFS = 8'h1c;
    localparam logic [7:0] BW_OFS   = 8'h1d;
    localparam logic [7:0] MUL_OFS  = 8'h1e;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BW_RST   = 8'h00;
    localparam logic [7:0] MUL_RST  = 8'h00;

    // Lock detector: reference edges per measurement window and hysteresis limits
    localparam logic [7:0] WINDOW_REF = 8'h10;
    localparam logic [7:0] LOCK_ENTER = 8'h01;
    localparam logic [7:0] LOCK_EXIT  = 8'h02;
    localparam logic [7:0] TRK_ENTER  = 8'h02;
    localparam logic [7:0] TRK_EXIT   = 8'h04;

    // Nominal VCO centre in Hz
    localparam logic [26:0] NOM_CENTRE_HZ = 27'h4b_0000;

    typedef struct packed {
        logic       irq_en;
        logic       change_flag;
        logic       power_on;
        logic       base_sel;
        logic [3:0] pad;
    } ctrl_type;

    typedef struct packed {
        logic       auto_mode;
        logic       locked;
        logic       tracking;
        logic [4:0] pad;
    } bw_type;

    typedef struct packed {
        logic [3:0] n;
        logic [3:0] l;
    } mul_type;

    typedef struct packed {
        logic up;
        logic down;
    } pump_type;

endpackage : pll_ctl_pkg

// ---- rtl/fb_divider.sv ----
// Modulo feedback divider: one pulse every N rising VCO edges.
// Assumes vco_rise_i is a one-cycle pulse per VCO rising edge.
`timescale 1ns/1ns
`default_nettype none
module fb_divider
    import pll_ctl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       enable_i,
    input  wire logic       vco_rise_i,
    input  wire logic [3:0] n_i,
    output logic            fb_pulse_o
);
    logic [3:0] count_r;
    logic [3:0] last;
    logic       wrap;

    // A zero divisor acts as one
    assign last = (n_i == 4'h0) ? 4'h0 : n_i - 4'h1;
    assign wrap = vco_rise_i && (count_r >= last);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_r <= 4'h0;
        end else if (!enable_i) begin
            count_r <= 4'h0;
        end else if (vco_rise_i) begin
            count_r <= wrap ? 4'h0 : count_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fb_pulse_o <= 1'b0;
        end else begin
            fb_pulse_o <= enable_i && wrap;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    div_pulse_cause_a: assert property (fb_pulse_o |-> $past(vco_rise_i) && $past(enable_i))
        else $error("feedback pulse without a VCO edge");
    div_unity_a: assert property (enable_i && vco_rise_i && n_i <= 4'h1 && $stable(n_i) |=> fb_pulse_o)
        else $error("divide by one missed a VCO edge");

endmodule : fb_divider
`default_nettype wire

// ---- rtl/lock_detect.sv ----
// Frequency lock detector: counts feedback pulses over a window of reference pulses.
// Assumes both inputs are one-cycle pulses in the system clock domain.
`timescale 1ns/1ns
`default_nettype none
module lock_detect
    import pll_ctl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic enable_i,
    input  wire logic ref_pulse_i,
    input  wire logic fb_pulse_i,
    output logic      locked_o,
    output logic      tracking_o
);
    logic [7:0] ref_cnt_r;
    logic [7:0] fb_cnt_r;
    logic [7:0] fb_total;
    logic [7:0] diff;
    logic       window_end;

    // Decisions happen only on reference edges
    assign window_end = enable_i && ref_pulse_i && (ref_cnt_r == WINDOW_REF - 8'h01);
    assign fb_total   = (fb_pulse_i && fb_cnt_r != 8'hff) ? fb_cnt_r + 8'h01 : fb_cnt_r;
    assign diff       = (fb_total > WINDOW_REF) ? fb_total - WINDOW_REF : WINDOW_REF - fb_total;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_cnt_r <= 8'h00;
        end else if (!enable_i || window_end) begin
            ref_cnt_r <= 8'h00;
        end else if (ref_pulse_i) begin
            ref_cnt_r <= ref_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fb_cnt_r <= 8'h00;
        end else if (!enable_i || window_end) begin
            fb_cnt_r <= 8'h00;
        end else begin
            fb_cnt_r <= fb_total;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            locked_o <= 1'b0;
        end else if (!enable_i) begin
            locked_o <= 1'b0;
        end else if (window_end) begin
            if (diff <= LOCK_ENTER) begin
                locked_o <= 1'b1;
            end else if (diff > LOCK_EXIT) begin
                locked_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tracking_o <= 1'b0;
        end else if (!enable_i) begin
            tracking_o <= 1'b0;
        end else if (window_end) begin
            if (diff <= TRK_ENTER) begin
                tracking_o <= 1'b1;
            end else if (diff > TRK_EXIT) begin
                tracking_o <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    lock_on_window_a: assert property (enable_i && $changed(locked_o) |-> $past(window_end) || !$past(enable_i))
        else $error("lock changed outside a window end");
    lock_hysteresis_a: assert property (window_end && diff > LOCK_ENTER && diff <= LOCK_EXIT |=> $stable(locked_o))
        else $error("lock moved inside the hysteresis band");

endmodule : lock_detect
`default_nettype wire

// ---- rtl/pll_lock_bandwidth_control.sv ----
// Digital control of a crystal-referenced loop: divider, phase compare, lock detect, registers.
// Assumes VCO and reference clocks arrive as levels synchronous to clk_i and slower than half of it.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module pll_lock_bandwidth_control
    import pll_ctl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        vco_clock_i,
    input  wire logic        reference_clock_i,
    output logic             vco_enable_o,
    output logic             base_clock_select_o,
    output logic             filter_tracking_o,
    output pump_type         pump_o,
    output logic             vco_feedback_clock_o,
    output logic             final_reference_clock_o,
    output logic             loop_irq_o,
    output logic      [26:0] vco_centre_hz_o
);

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    ctrl_type    ctrl_r;
    bw_type      bw_r;
    mul_type     mul_r;
    ctrl_type    ctrl_wd;
    bw_type      bw_wd;
    logic [7:0]  rdata_r;
    logic [7:0]  rd_val;
    logic        vco_prev_r;
    logic        ref_prev_r;
    logic        ref_q_r;
    logic        fb_q_r;
    logic        lock_prev_r;
    logic        up_r;
    logic        down_r;
    logic [26:0] centre_r;
    logic        vco_rise;
    logic        ref_rise;
    logic        fb_pulse;
    logic        det_locked;
    logic        det_tracking;
    logic        loop_active;
    logic        wr_ctrl;
    logic        wr_bw;
    logic        wr_mul;
    logic        rd_ctrl;
    logic        lock_set;

    assign ctrl_wd     = ctrl_type'(wdata_i);
    assign bw_wd       = bw_type'(wdata_i);
    assign wr_ctrl     = wr_i && reg_hit(addr_i, CTRL_OFS);
    assign wr_bw       = wr_i && reg_hit(addr_i, BW_OFS);
    assign wr_mul      = wr_i && reg_hit(addr_i, MUL_OFS);
    assign rd_ctrl     = rd_i && reg_hit(addr_i, CTRL_OFS);
    // Loop runs only when powered and a range factor is programmed
    assign loop_active = ctrl_r.power_on && (mul_r.l != 4'h0);
    assign vco_rise    = vco_clock_i && !vco_prev_r;
    assign ref_rise    = reference_clock_i && !ref_prev_r;
    assign lock_set    = bw_r.auto_mode && (det_locked != lock_prev_r);

    // Edge capture of the incoming clocks
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vco_prev_r <= 1'b0;
            ref_prev_r <= 1'b0;
        end else begin
            vco_prev_r <= vco_clock_i;
            ref_prev_r <= reference_clock_i;
        end
    end

    fb_divider i_fb_divider (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .enable_i   (loop_active),
        .vco_rise_i (vco_rise),
        .n_i        (mul_r.n),
        .fb_pulse_o (fb_pulse)
    );

    lock_detect i_lock_detect (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .enable_i    (loop_active && bw_r.auto_mode),
        .ref_pulse_i (ref_rise),
        .fb_pulse_i  (fb_pulse),
        .locked_o    (det_locked),
        .tracking_o  (det_tracking)
    );

    // Phase detector: up from reference edge until feedback edge, down the other way
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_r   <= 1'b0;
            down_r <= 1'b0;
        end else if (!loop_active || (up_r && down_r)) begin
            up_r   <= 1'b0;
            down_r <= 1'b0;
        end else begin
            up_r   <= up_r || ref_rise;
            down_r <= down_r || fb_pulse;
        end
    end

    // Control register: enable, flag, power and base clock select
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r <= ctrl_type'(CTRL_RST);
        end else begin
            if (!bw_r.auto_mode) begin
                ctrl_r.irq_en <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_r.irq_en <= ctrl_wd.irq_en;
            end
            if (!bw_r.auto_mode) begin
                ctrl_r.change_flag <= 1'b0;
            end else begin
                ctrl_r.change_flag <= lock_set || (ctrl_r.change_flag && !rd_ctrl);
            end
            if (wr_ctrl && !(ctrl_r.base_sel && !ctrl_wd.power_on)) begin
                ctrl_r.power_on <= ctrl_wd.power_on;
            end
            if (mul_r.l == 4'h0) begin
                ctrl_r.base_sel <= 1'b0;
            end else if (wr_ctrl) begin
                if (!ctrl_wd.base_sel) begin
                    ctrl_r.base_sel <= 1'b0;
                end else if (ctrl_r.power_on && ctrl_wd.power_on) begin
                    ctrl_r.base_sel <= 1'b1;
                end
            end
            ctrl_r.pad <= 4'h0;
        end
    end

    // Bandwidth register: auto bit, lock indicator, filter mode
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bw_r <= bw_type'(BW_RST);
        end else begin
            if (wr_bw) begin
                bw_r.auto_mode <= bw_wd.auto_mode;
            end
            bw_r.locked <= bw_r.auto_mode && det_locked;
            if (bw_r.auto_mode) begin
                bw_r.tracking <= det_tracking;
            end else if (wr_bw) begin
                bw_r.tracking <= bw_wd.tracking;
            end
            bw_r.pad <= 5'h00;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mul_r <= mul_type'(MUL_RST);
        end else if (wr_mul) begin
            mul_r <= mul_type'(wdata_i);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lock_prev_r <= 1'b0;
        end else begin
            lock_prev_r <= det_locked;
        end
    end

    always_comb begin
        rd_val = 8'h00;
        case (addr_i)
            CTRL_OFS: rd_val = {ctrl_r.irq_en && bw_r.auto_mode, ctrl_r.change_flag && bw_r.auto_mode,
                                ctrl_r.power_on, ctrl_r.base_sel, 4'h0};
            BW_OFS:   rd_val = {bw_r.auto_mode, bw_r.locked, bw_r.tracking, 5'h00};
            MUL_OFS:  rd_val = mul_r;
            default:  rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            rdata_r <= rd_val;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Registered copies of the detector clocks and the range centre
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_q_r  <= 1'b0;
            fb_q_r   <= 1'b0;
            centre_r <= 27'h000_0000;
        end else begin
            ref_q_r  <= ref_rise;
            fb_q_r   <= fb_pulse;
            centre_r <= 27'(NOM_CENTRE_HZ * {23'h00_0000, mul_r.l});
        end
    end

    assign rdata_o                 = rdata_r;
    assign vco_enable_o            = loop_active;
    assign base_clock_select_o     = ctrl_r.base_sel;
    assign filter_tracking_o       = bw_r.tracking;
    assign pump_o                  = '{up: up_r, down: down_r};
    assign vco_feedback_clock_o    = fb_q_r;
    assign final_reference_clock_o = ref_q_r;
    assign loop_irq_o              = bw_r.auto_mode && ctrl_r.irq_en && ctrl_r.change_flag;
    assign vco_centre_hz_o         = centre_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence lock_toggle_s;
        bw_r.auto_mode && ctrl_r.irq_en && lock_set && !wr_bw && !wr_ctrl;
    endsequence
    sequence ref_only_s;
        loop_active && ref_rise && !fb_pulse && !up_r && !down_r;
    endsequence

    irq_on_toggle_a: assert property (lock_toggle_s |=> loop_irq_o)
        else $error("lock toggle did not raise the interrupt");
    flag_read_clear_a: assert property (rd_ctrl && !lock_set && bw_r.auto_mode ##1 !lock_set |=> !ctrl_r.change_flag)
        else $error("control read did not clear the change flag");
    manual_quiet_a: assert property (!bw_r.auto_mode && !$past(bw_r.auto_mode) |-> !loop_irq_o && !bw_r.locked)
        else $error("manual mode shows lock or interrupt");
    select_refused_a: assert property (wr_ctrl && ctrl_wd.base_sel && !ctrl_r.power_on |=> !ctrl_r.base_sel)
        else $error("VCO clock selected while loop off");
    power_held_a: assert property (wr_ctrl && ctrl_r.base_sel && !ctrl_wd.power_on |=> ctrl_r.power_on)
        else $error("loop turned off while VCO clock selected");
    range_zero_a: assert property (mul_r.l == 4'h0 |-> !vco_enable_o ##1 !ctrl_r.base_sel)
        else $error("zero range factor left loop or VCO select active");
    read_data_a: assert property (rd_i && reg_hit(addr_i, MUL_OFS) && !wr_i |=> rdata_o == $past(mul_r))
        else $error("multiplier read returned wrong data");
    pump_up_a: assert property (ref_only_s |=> up_r && !down_r ##1 up_r || !loop_active)
        else $error("reference lead did not drive the up pulse");
    auto_track_a: assert property (bw_r.auto_mode ##1 bw_r.auto_mode |-> bw_r.tracking == $past(det_tracking))
        else $error("auto mode tracking bit not following detector");
    manual_track_a: assert property (!bw_r.auto_mode && wr_bw |=> bw_r.tracking == $past(bw_wd.tracking))
        else $error("manual tracking write not taken");

endmodule : pll_lock_bandwidth_control
`default_nettype wire

// ---- testbench/pll_lock_bandwidth_control_tb.sv ----
// Self-checking bench for the loop control block: registers, interlocks, divider, pumps, lock detect.
// Assumes the design package and sources are compiled first; bench drives VCO and reference levels.
`timescale 1ns/1ns
`default_nettype none
module pll_lock_bandwidth_control_tb import pll_ctl_pkg::*; ;
    logic        clk_i;
    logic        nrst_i;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        vco = 1'b0;
    logic        rf = 1'b0;
    logic        vco_en;
    logic        base_sel;
    logic        trk;
    pump_type    pump;
    logic        fb;
    logic        fref;
    logic        loop_irq_o;
    logic [26:0] centre;
    int          num_errors = 0;
    int          n_tests = 0;
    int          vhalf = 0;
    int          rhalf = 0;
    int          vcnt = 0;
    int          rcnt = 0;
    int          n_fb, n_rf, n_up, n_dn;

    pll_lock_bandwidth_control i_pll_lock_bandwidth_control (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .vco_clock_i(vco), .reference_clock_i(rf), .vco_enable_o(vco_en),
        .base_clock_select_o(base_sel), .filter_tracking_o(trk), .pump_o(pump),
        .vco_feedback_clock_o(fb), .final_reference_clock_o(fref), .loop_irq_o(loop_irq_o),
        .vco_centre_hz_o(centre)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Slow clock levels; a half period of 0 freezes the level
    always @(posedge clk_i) begin
        vcnt <= (vcnt + 1 >= vhalf) ? 0 : vcnt + 1;
        rcnt <= (rcnt + 1 >= rhalf) ? 0 : rcnt + 1;
        if (vhalf != 0 && vcnt + 1 >= vhalf) vco <= ~vco;
        if (rhalf != 0 && rcnt + 1 >= rhalf) rf <= ~rf;
    end

    always @(negedge clk_i) begin
        n_fb += int'(fb);
        n_rf += int'(fref);
        n_up += int'(pump.up);
        n_dn += int'(pump.down);
    end

    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_hz(input string nm, input logic [26:0] e, input logic [26:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_hz

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1;
        chk_reg(nm, e, rdata);
    endtask : rd_chk

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic run_cnt(input int cyc);
        n_fb = 0;
        n_rf = 0;
        n_up = 0;
        n_dn = 0;
        step(cyc);
    endtask : run_cnt

    function automatic logic near(input int g, input int e);
        return (g >= e - 1) && (g <= e + 1);
    endfunction : near

    task automatic wait_irq(input logic e);
        int i;
        for (i = 0; i < 3000 && loop_irq_o !== e; i++) @(negedge clk_i);
        chk_bit("irq", e, loop_irq_o);
    endtask : wait_irq

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task automatic t_reset();
        rd_chk("ctrl", CTRL_OFS, 8'h00);
        rd_chk("bw", BW_OFS, 8'h00);
        rd_chk("mul", MUL_OFS, 8'h00);
        wr_reg(8'h1f, 8'hff);
        rd_chk("unmapped", 8'h1f, 8'h00);
        wr_reg(CTRL_OFS, 8'h10);
        rd_chk("select unpowered", CTRL_OFS, 8'h00);
        chk_bit("vco enable", 1'b0, vco_en);
        $display("test reset done");
    endtask : t_reset

    task automatic t_setup();
        // N rounded from four times a 5 MHz bus over a 5 MHz reference
        wr_reg(MUL_OFS, {4'((4 * 5 + 5 / 2) / 5), 4'h7});
        wr_reg(CTRL_OFS, 8'h20);
        step(1);
        chk_bit("vco enable", 1'b1, vco_en);
        chk_hz("centre", 27'(7) * NOM_CENTRE_HZ, centre);
        rd_chk("mul", MUL_OFS, 8'h47);
        $display("test setup done");
    endtask : t_setup

    task automatic t_interlock();
        wr_reg(CTRL_OFS, 8'h30);
        rd_chk("select", CTRL_OFS, 8'h30);
        chk_bit("base select", 1'b1, base_sel);
        wr_reg(CTRL_OFS, 8'h10);
        rd_chk("off while selected", CTRL_OFS, 8'h30);
        wr_reg(CTRL_OFS, 8'h00);
        rd_chk("deselect and off", CTRL_OFS, 8'h20);
        wr_reg(CTRL_OFS, 8'h30);
        wr_reg(MUL_OFS, 8'h40);
        step(2);
        chk_bit("base select l0", 1'b0, base_sel);
        chk_bit("vco enable l0", 1'b0, vco_en);
        $display("test interlock done");
    endtask : t_interlock

    task automatic t_manual();
        wr_reg(CTRL_OFS, 8'h00);
        wr_reg(BW_OFS, 8'h00);
        wr_reg(MUL_OFS, 8'h27);
        wr_reg(CTRL_OFS, 8'h20);
        step(64);
        wr_reg(BW_OFS, 8'h20);
        rd_chk("bw manual", BW_OFS, 8'h20);
        chk_bit("tracking", 1'b1, trk);
        step(64);
        wr_reg(CTRL_OFS, 8'h30);
        step(1);
        chk_bit("manual select", 1'b1, base_sel);
        wr_reg(CTRL_OFS, 8'h20);
        wr_reg(BW_OFS, 8'h00);
        step(1);
        chk_bit("acquisition", 1'b0, trk);
        wr_reg(CTRL_OFS, 8'ha0);
        rd_chk("irq en manual", CTRL_OFS, 8'h20);
        vhalf = 4;
        rhalf = 8;
        step(700);
        rd_chk("lock manual", BW_OFS, 8'h00);
        chk_bit("irq manual", 1'b0, loop_irq_o);
        $display("test manual done");
    endtask : t_manual

    task automatic t_divider();
        vhalf = 0;
        rhalf = 3;
        // Let pending pump pairs clear; with no feedback the up pump then stays on
        step(30);
        run_cnt(120);
        chk_bit("ref count", 1'b1, near(n_rf, 20));
        chk_bit("up held", 1'b1, n_up == 120);
        chk_bit("no down", 1'b1, n_dn == 0);
        rhalf = 0;
        vhalf = 2;
        wr_reg(MUL_OFS, 8'h37);
        // First feedback pulse pairs with the held up pump, the second holds down
        step(40);
        run_cnt(120);
        chk_bit("fb count n3", 1'b1, near(n_fb, 10));
        chk_bit("down held", 1'b1, n_dn == 120);
        wr_reg(MUL_OFS, 8'h07);
        run_cnt(120);
        chk_bit("fb count n0", 1'b1, near(n_fb, 30));
        $display("test divider done");
    endtask : t_divider

    task automatic t_auto();
        wr_reg(MUL_OFS, 8'h27);
        wr_reg(BW_OFS, 8'h80);
        wr_reg(CTRL_OFS, 8'ha0);
        vhalf = 4;
        rhalf = 8;
        wait_irq(1'b1);
        step(2);
        rd_chk("bw locked", BW_OFS, 8'he0);
        chk_bit("auto tracking", 1'b1, trk);
        wr_reg(BW_OFS, 8'h80);
        rd_chk("bw read only", BW_OFS, 8'he0);
        rd_chk("flag set", CTRL_OFS, 8'he0);
        rd_chk("flag cleared", CTRL_OFS, 8'ha0);
        chk_bit("irq cleared", 1'b0, loop_irq_o);
        wr_reg(CTRL_OFS, 8'hb0);
        step(1);
        chk_bit("auto select", 1'b1, base_sel);
        vhalf = 0;
        wait_irq(1'b1);
        wr_reg(CTRL_OFS, 8'ha0);
        step(1);
        chk_bit("unlock deselect", 1'b0, base_sel);
        step(300);
        rd_chk("bw unlocked", BW_OFS, 8'h80);
        chk_bit("auto acquisition", 1'b0, trk);
        wr_reg(CTRL_OFS, 8'h20);
        step(1);
        chk_bit("irq masked", 1'b0, loop_irq_o);
        rd_chk("flag kept", CTRL_OFS, 8'h60);
        $display("test auto done");
    endtask : t_auto

    initial begin
        #(50 * 40000);
        num_errors++;
        $display("[ERR] run time expected done seen timeout");
        wrap_up();
    end

    initial begin
        nrst_i = 1'b0;
        addr   = 8'h00;
        wdata  = 8'h00;
        wr     = 1'b0;
        rd     = 1'b0;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_setup();
        t_interlock();
        t_manual();
        t_divider();
        t_auto();
        wrap_up();
    end
endmodule : pll_lock_bandwidth_control_tb
`default_nettype wire
